/* fb_slave_pkg.sv */
package fb_slave_pkg;

    localparam int unsigned CLK_HZ = 200_000_000;
    // half periods of the blink rates, 50 percent duty
    localparam int unsigned BLINK_1HZ_HZ = 1;
    localparam int unsigned HALF_4HZ_CYC = CLK_HZ / (4 * 2);
    localparam logic [24:0] HALF_4HZ_MAX = 25'(HALF_4HZ_CYC - 1);
    localparam logic [2:0] PHASE_RESET = 3'h0;

    localparam logic [6:0] ADDR_MIN = 7'h01;
    localparam logic [6:0] ADDR_MAX = 7'h63;
    localparam logic [3:0] DIGIT_MAX = 4'h9;
    localparam logic [6:0] ADDR_RESET = 7'h00;

    // bit rates, shortest bit first: 12M 6M 3M 1.5M 500k 187.5k 93.75k 45.45k 19.2k 9.6k
    localparam int unsigned RATE_COUNT = 10;
    localparam logic [3:0] RATE_RESET = 4'h0;
    localparam logic [15:0] RATE_BIT_CYC [RATE_COUNT] = '{
        16'd17, 16'd33, 16'd67, 16'd133, 16'd400,
        16'd1067, 16'd2133, 16'd4400, 16'd10417, 16'd20833
    };
    localparam logic [15:0] EDGE_CNT_RESET = 16'h0000;

    localparam logic [7:0] SLOT_DIV = 8'hff;

    typedef enum logic [1:0] {
        boot_wait_type = 2'b00,
        boot_run_type = 2'b01,
        boot_fault_type = 2'b10
    } boot_state_type;

    typedef struct packed {
        logic chip_rom_fail;
        logic ram_fail;
        logic dpram_fail;
        logic init_done;
    } selftest_type;

    typedef struct packed {
        logic io_size_err;
        logic prm_err;
        logic asic_enable_err;
        logic online;
        logic acyclic_busy;
    } net_status_type;

    typedef struct packed {
        logic red;
        logic green;
    } led_type;

    typedef struct packed {
        logic [7:0] slot;
        logic [7:0] index;
    } param_loc_type;

    function automatic logic [6:0] addr_from_digits(input logic [3:0] tens,
                                                    input logic [3:0] units);
        logic [6:0] t;
        logic [6:0] a;
        // widen first so the shifts keep the upper bits
        t = {3'h0, tens};
        a = (t << 3) + (t << 1) + {3'h0, units};
        return a;
    endfunction

    function automatic param_loc_type param_map(input logic [15:0] num);
        logic [15:0] z;
        param_loc_type r;
        z = (num == 16'h0000) ? 16'h0000 : num - 16'h0001;
        r.slot = 8'(z / 16'(SLOT_DIV));
        r.index = 8'(z % 16'(SLOT_DIV));
        return r;
    endfunction

endpackage

/* fb_slave_status.sv */
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - reply only to master requests, never initiate
// - detect bit rate automatically, ten rates
// - address equals ten times left plus right
// - latch address once at initialisation
// - red 2/1/4 Hz per self-test fault
// - green 2 Hz uninitialised, 1 Hz operating
// - red fault holds until power cycle
// - diagnostic red 1 Hz on io size mismatch
// - diagnostic red 2 Hz on parameter mismatch
// - diagnostic red 4 Hz enable error, else off
// - green on-line lit while on-line
// - red off-line lit while off-line
// - acyclic led lit while request busy
// - parameter n maps to slot and index
// - parameter values are one 16-bit word
module fb_slave_status (
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic [3:0] sw_tens_i,
    input wire logic [3:0] sw_units_i,
    input wire logic rx_line_i,
    input wire logic frame_req_i,
    input wire logic [7:0] frame_dst_i,
    input wire logic reply_ready_i,
    input wire fb_slave_pkg::selftest_type selftest_i,
    input wire fb_slave_pkg::net_status_type net_i,
    input wire logic param_req_i,
    input wire logic [15:0] param_num_i,
    input wire logic [15:0] param_val_i,
    output logic [6:0] node_addr_o,
    output logic addr_valid_o,
    output logic [3:0] rate_sel_o,
    output logic rate_locked_o,
    output logic tx_enable_o,
    output fb_slave_pkg::led_type board_led_o,
    output logic diag_led_o,
    output logic online_led_o,
    output logic offline_led_o,
    output logic acyclic_led_o,
    output fb_slave_pkg::param_loc_type param_loc_o,
    output logic [15:0] param_word_o,
    output logic param_valid_o
);
    import fb_slave_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers; first stage read only by the second
    logic [1:0] rx_sync_reg, rx_sync_next;
    logic [3:0] tens_s1_reg, tens_s2_reg, units_s1_reg, units_s2_reg;
    logic rx_prev_reg, rx_prev_next;

    always_comb begin
        rx_sync_next = {rx_sync_reg[0], rx_line_i};
        rx_prev_next = rx_sync_reg[1];
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rx_sync_reg <= 2'h3;
            rx_prev_reg <= 1'b1;
            tens_s1_reg <= 4'h0;
            tens_s2_reg <= 4'h0;
            units_s1_reg <= 4'h0;
            units_s2_reg <= 4'h0;
        end else begin
            rx_sync_reg <= rx_sync_next;
            rx_prev_reg <= rx_prev_next;
            tens_s1_reg <= sw_tens_i;
            tens_s2_reg <= tens_s1_reg;
            units_s1_reg <= sw_units_i;
            units_s2_reg <= units_s1_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // blink divider, free running
    logic [24:0] div_reg, div_next;
    logic [2:0] phase_reg, phase_next;

    always_comb begin
        div_next = div_reg + 25'h0000001;
        phase_next = phase_reg;
        if (div_reg == HALF_4HZ_MAX) begin
            div_next = 25'h0000000;
            phase_next = phase_reg + 3'h1; // bit0 4 Hz, bit1 2 Hz, bit2 1 Hz
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            div_reg <= 25'h0000000;
            phase_reg <= PHASE_RESET;
        end else begin
            div_reg <= div_next;
            phase_reg <= phase_next;
        end
    end

    wire logic blink_4 = ~phase_reg[0];
    wire logic blink_2 = ~phase_reg[1];
    wire logic blink_1 = ~phase_reg[2];

    ////////////////////////////////////////////////////////////////////////
    // initialisation, address capture and sticky faults
    boot_state_type boot_reg, boot_next;
    logic [6:0] addr_reg, addr_next;
    logic addr_ok_reg, addr_ok_next;
    logic [2:0] fault_reg, fault_next; // chip/rom, ram, dpram

    always_comb begin
        boot_next = boot_reg;
        addr_next = addr_reg;
        addr_ok_next = addr_ok_reg;
        // only reset clears the latched faults
        fault_next = fault_reg | {selftest_i.chip_rom_fail, selftest_i.ram_fail,
                                  selftest_i.dpram_fail};
        case (boot_reg)
            boot_wait_type: begin
                if (fault_next != 3'h0) begin
                    boot_next = boot_fault_type;
                end else if (selftest_i.init_done) begin
                    addr_next = addr_from_digits(tens_s2_reg, units_s2_reg);
                    addr_ok_next = (tens_s2_reg <= DIGIT_MAX) && (units_s2_reg <= DIGIT_MAX)
                        && (addr_next >= ADDR_MIN) && (addr_next <= ADDR_MAX);
                    boot_next = boot_run_type;
                end
            end
            boot_run_type: begin
                if (fault_next != 3'h0) begin
                    boot_next = boot_fault_type;
                end
            end
            boot_fault_type: boot_next = boot_fault_type;
            default: boot_next = boot_wait_type;
        endcase
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            boot_reg <= boot_wait_type;
            addr_reg <= ADDR_RESET;
            addr_ok_reg <= 1'b0;
            fault_reg <= 3'h0;
        end else begin
            boot_reg <= boot_next;
            addr_reg <= addr_next;
            addr_ok_reg <= addr_ok_next;
            fault_reg <= fault_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bit rate detection from the first pulse between edges that fits a bit time
    logic [15:0] run_reg, run_next;
    logic [3:0] rate_reg, rate_next;
    logic lock_reg, lock_next;

    always_comb begin
        run_next = (run_reg == 16'hffff) ? run_reg : run_reg + 16'h0001;
        rate_next = rate_reg;
        lock_next = lock_reg;
        if (rx_sync_reg[1] != rx_prev_reg) begin
            run_next = EDGE_CNT_RESET;
            if (!lock_reg) begin
                // pick the rate whose bit time the pulse is within one eighth of; the shortest such bit wins
                for (int i = RATE_COUNT - 1; i >= 0; i--) begin
                    if (run_reg >= RATE_BIT_CYC[i] - (RATE_BIT_CYC[i] >> 3)
                        && run_reg <= RATE_BIT_CYC[i] + (RATE_BIT_CYC[i] >> 3)) begin
                        rate_next = 4'(i);
                        lock_next = 1'b1;
                    end
                end
            end
        end
        // silence never unlocks; only reset starts a new search
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            run_reg <= EDGE_CNT_RESET;
            rate_reg <= RATE_RESET;
            lock_reg <= 1'b0;
        end else begin
            run_reg <= run_next;
            rate_reg <= rate_next;
            lock_reg <= lock_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // reply gating, leds and parameter mapping
    logic tx_reg, tx_next;
    led_type board_reg, board_next;
    logic diag_reg, diag_next, on_reg, on_next, off_reg, off_next, acy_reg, acy_next;
    param_loc_type loc_reg, loc_next;
    logic [15:0] word_reg, word_next;
    logic pv_reg, pv_next;

    always_comb begin
        // transmit only after a request addressed to this node
        tx_next = tx_reg;
        if (frame_req_i && lock_reg && addr_ok_reg && boot_reg == boot_run_type
            && frame_dst_i == {1'b0, addr_reg}) begin
            tx_next = 1'b1;
        end else if (reply_ready_i) begin
            tx_next = 1'b0;
        end
        board_next = '{red: 1'b0, green: 1'b0};
        if (fault_reg[2]) begin
            board_next.red = blink_2;
        end else if (fault_reg[1]) begin
            board_next.red = blink_1;
        end else if (fault_reg[0]) begin
            board_next.red = blink_4;
        end else if (boot_reg == boot_run_type) begin
            board_next.green = blink_1;
        end else begin
            board_next.green = blink_2;
        end
        if (net_i.asic_enable_err) begin
            diag_next = blink_4;
        end else if (net_i.prm_err) begin
            diag_next = blink_2;
        end else if (net_i.io_size_err) begin
            diag_next = blink_1;
        end else begin
            diag_next = 1'b0;
        end
        on_next = net_i.online;
        off_next = ~net_i.online;
        acy_next = net_i.acyclic_busy;
        loc_next = loc_reg;
        word_next = word_reg;
        pv_next = param_req_i;
        if (param_req_i) begin
            loc_next = param_map(param_num_i);
            word_next = param_val_i;
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tx_reg <= 1'b0;
            board_reg <= '{red: 1'b0, green: 1'b0};
            diag_reg <= 1'b0;
            on_reg <= 1'b0;
            off_reg <= 1'b1;
            acy_reg <= 1'b0;
            loc_reg <= '{slot: 8'h00, index: 8'h00};
            word_reg <= 16'h0000;
            pv_reg <= 1'b0;
        end else begin
            tx_reg <= tx_next;
            board_reg <= board_next;
            diag_reg <= diag_next;
            on_reg <= on_next;
            off_reg <= off_next;
            acy_reg <= acy_next;
            loc_reg <= loc_next;
            word_reg <= word_next;
            pv_reg <= pv_next;
        end
    end

    assign node_addr_o = addr_reg;
    assign addr_valid_o = addr_ok_reg;
    assign rate_sel_o = rate_reg;
    assign rate_locked_o = lock_reg;
    assign tx_enable_o = tx_reg;
    assign board_led_o = board_reg;
    assign diag_led_o = diag_reg;
    assign online_led_o = on_reg;
    assign offline_led_o = off_reg;
    assign acyclic_led_o = acy_reg;
    assign param_loc_o = loc_reg;
    assign param_word_o = word_reg;
    assign param_valid_o = pv_reg;

endmodule

`default_nettype wire

/* fb_slave_checker_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module fb_slave_checker (
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic frame_req_i,
    input wire logic [7:0] frame_dst_i,
    input wire logic reply_ready_i,
    input wire fb_slave_pkg::selftest_type selftest_i,
    input wire fb_slave_pkg::net_status_type net_i,
    input wire logic param_req_i,
    input wire logic [15:0] param_num_i,
    input wire logic [15:0] param_val_i,
    input wire logic [6:0] node_addr_o,
    input wire logic addr_valid_o,
    input wire logic [3:0] rate_sel_o,
    input wire logic rate_locked_o,
    input wire logic tx_enable_o,
    input wire fb_slave_pkg::led_type board_led_o,
    input wire logic online_led_o,
    input wire logic offline_led_o,
    input wire logic acyclic_led_o,
    input wire fb_slave_pkg::param_loc_type param_loc_o,
    input wire logic [15:0] param_word_o,
    input wire logic param_valid_o
);
    import fb_slave_pkg::*;
    logic fault_seen_reg;
    logic fault_seen_next;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);
    ////////////////////////////////////////////////////////////
    // remembers any fault so green can be checked long after the input drops
    always_comb begin
        fault_seen_next = fault_seen_reg | (|selftest_i[3:1]);
    end
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            fault_seen_reg <= 1'b0;
        end else begin
            fault_seen_reg <= fault_seen_next;
        end
    end
    ////////////////////////////////////////////////////////////
    property p_reply; $rose(tx_enable_o) |-> $past(frame_req_i) && addr_valid_o
        && rate_locked_o && $past(frame_dst_i) == {1'b0, node_addr_o}; endproperty
    a_reply: assert property (p_reply) else $error("reply without own request");
    property p_drop; tx_enable_o && reply_ready_i && !frame_req_i |=> !tx_enable_o; endproperty
    a_drop: assert property (p_drop) else $error("reply enable held");
    property p_addr; addr_valid_o |-> node_addr_o inside {[ADDR_MIN:ADDR_MAX]}; endproperty
    a_addr: assert property (p_addr) else $error("valid address out of range");
    property p_latch; addr_valid_o |=> addr_valid_o && $stable(node_addr_o); endproperty
    a_latch: assert property (p_latch) else $error("address changed");
    property p_lock; rate_locked_o |=> rate_locked_o && $stable(rate_sel_o); endproperty
    a_lock: assert property (p_lock) else $error("rate lock lost");
    property p_sticky; fault_seen_reg |=> ##1 !board_led_o.green; endproperty
    a_sticky: assert property (p_sticky) else $error("green after fault");
    property p_line; online_led_o != offline_led_o; endproperty
    a_line: assert property (p_line) else $error("line leds agree");
    property p_acyc; $rose(net_i.acyclic_busy) |=> acyclic_led_o; endproperty
    a_acyc: assert property (p_acyc) else $error("acyclic led dark");
    property p_map; param_req_i && param_num_i != 16'h0000 |=> param_valid_o
        && param_loc_o == {8'(($past(param_num_i) - 16'h1) / 16'd255),
        8'(($past(param_num_i) - 16'h1) % 16'd255)}; endproperty
    a_map: assert property (p_map) else $error("parameter location wrong");
    property p_word; param_req_i |=> param_word_o == $past(param_val_i); endproperty
    a_word: assert property (p_word) else $error("parameter word wrong");
endmodule
bind fb_slave_status fb_slave_checker u_checker (
    .mclk_i, .arst_n_i, .frame_req_i, .frame_dst_i, .reply_ready_i, .selftest_i, .net_i,
    .param_req_i, .param_num_i, .param_val_i, .node_addr_o, .addr_valid_o, .rate_sel_o,
    .rate_locked_o, .tx_enable_o, .board_led_o, .online_led_o, .offline_led_o,
    .acyclic_led_o, .param_loc_o, .param_word_o, .param_valid_o
);
`default_nettype wire

/* fb_master_model.sv */
`timescale 1ns/1ps
`default_nettype none
module fb_master_model (
    input wire logic mclk_i,
    output logic rx_line_o,
    output logic frame_req_o,
    output logic [7:0] frame_dst_o,
    output logic reply_ready_o
);
    initial begin
        rx_line_o = 1'b1;
        frame_req_o = 1'b0;
        frame_dst_o = 8'h00;
        reply_ready_o = 1'b0;
    end
    // one start bit, held low for cyc cycles at whatever rate the caller gives
    task automatic send_bit(input int cyc);
        @(negedge mclk_i);
        rx_line_o = 1'b0;
        repeat (cyc) @(negedge mclk_i);
        rx_line_o = 1'b1;
    endtask
    // destination is scrambled once released, so stale values never match
    task automatic request(input logic [7:0] dst);
        @(negedge mclk_i);
        frame_req_o = 1'b1;
        frame_dst_o = dst;
        @(negedge mclk_i);
        frame_req_o = 1'b0;
        frame_dst_o = ~dst;
    endtask
    task automatic finish_reply;
        @(negedge mclk_i);
        reply_ready_o = 1'b1;
        @(negedge mclk_i);
        reply_ready_o = 1'b0;
    endtask
endmodule
`default_nettype wire

/* tb_fieldbus_slave_status_logic.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(name, exp, got) begin checks_done++; if ((got) !== (exp)) begin errors++; \
    $display("Error %s expected %0h seen %0h", name, exp, got); end end
module tb_fieldbus_slave_status_logic;
    import fb_slave_pkg::*;
    logic mclk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [3:0] sw_tens_i = 4'h0;
    logic [3:0] sw_units_i = 4'h0;
    logic rx_line_i, frame_req_i, reply_ready_i;
    logic [7:0] frame_dst_i;
    selftest_type selftest_i = '0;
    net_status_type net_i = '0;
    logic param_req_i = 1'b0;
    logic [15:0] param_num_i = 16'h0000;
    logic [15:0] param_val_i = 16'h0000;
    logic [6:0] node_addr_o;
    logic [3:0] rate_sel_o;
    logic addr_valid_o, rate_locked_o, tx_enable_o, diag_led_o, online_led_o;
    logic offline_led_o, acyclic_led_o, param_valid_o;
    led_type board_led_o;
    param_loc_type param_loc_o;
    logic [15:0] param_word_o;
    int errors = 0;
    int checks_done = 0;
    int cycles = 0;
    fb_slave_status u_dut (
        .mclk_i, .arst_n_i, .sw_tens_i, .sw_units_i, .rx_line_i, .frame_req_i, .frame_dst_i,
        .reply_ready_i, .selftest_i, .net_i, .param_req_i, .param_num_i, .param_val_i,
        .node_addr_o, .addr_valid_o, .rate_sel_o, .rate_locked_o, .tx_enable_o,
        .board_led_o, .diag_led_o, .online_led_o, .offline_led_o, .acyclic_led_o,
        .param_loc_o, .param_word_o, .param_valid_o
    );
    fb_master_model u_master (
        .mclk_i, .rx_line_o(rx_line_i), .frame_req_o(frame_req_i), .frame_dst_o(frame_dst_i),
        .reply_ready_o(reply_ready_i)
    );
    initial begin
        forever #2.5 mclk_i = ~mclk_i;
    end
    // the slowest rate dominates; the ceiling leaves room for all of them
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 60000) begin
            errors++;
            complete_run();
        end
    end
    ////////////////////////////////////////////////////////////
    task automatic complete_run;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // switches settle before init so the sync stages hold them
    task automatic boot(input logic [3:0] tens, input logic [3:0] units);
        arst_n_i = 1'b0;
        sw_tens_i = tens;
        sw_units_i = units;
        selftest_i = '0;
        net_i = '0;
        repeat (12) @(negedge mclk_i);
        `CHK("offline in reset", 1'b1, offline_led_o)
        arst_n_i = 1'b1;
        repeat (3) @(negedge mclk_i);
        `CHK("green before init", 2'b01, board_led_o)
        selftest_i.init_done = 1'b1;
        repeat (3) @(negedge mclk_i);
    endtask
    task automatic t_addr;
        logic [3:0] tv [5] = '{4'h4, 4'h9, 4'h0, 4'h0, 4'ha};
        logic [3:0] uv [5] = '{4'h2, 4'h9, 4'h0, 4'h1, 4'h0};
        logic [6:0] want;
        for (int i = 0; i < 5; i++) begin
            boot(tv[i], uv[i]);
            want = 7'(tv[i] * 10 + uv[i]);
            `CHK("node address", want, node_addr_o)
            `CHK("address valid", want inside {[7'h01:7'h63]}, addr_valid_o)
        end
    endtask
    task automatic t_rate;
        for (int i = 0; i < RATE_COUNT; i++) begin
            boot(4'h1, 4'h2);
            u_master.send_bit(int'(RATE_BIT_CYC[i]));
            for (int w = 0; w < 8 && rate_locked_o !== 1'b1; w++) begin
                @(negedge mclk_i);
            end
            `CHK("rate lock", 1'b1, rate_locked_o)
            `CHK("rate index", 4'(i), rate_sel_o)
        end
    endtask
    task automatic t_reply;
        boot(4'h4, 4'h2);
        u_master.send_bit(int'(RATE_BIT_CYC[0]));
        sw_tens_i = 4'h7;
        sw_units_i = 4'h7;
        repeat (4) @(negedge mclk_i);
        `CHK("address after switch change", 7'h2a, node_addr_o)
        u_master.request(8'h2b);
        @(negedge mclk_i);
        `CHK("reply for other node", 1'b0, tx_enable_o)
        u_master.request(8'h2a);
        repeat (5) @(negedge mclk_i);
        `CHK("reply enabled", 1'b1, tx_enable_o)
        u_master.finish_reply();
        `CHK("reply released", 1'b0, tx_enable_o)
    endtask
    task automatic t_leds;
        net_status_type nv [4] = '{5'h10, 5'h08, 5'h04, 5'h00};
        boot(4'h1, 4'h2);
        `CHK("board green", 2'b01, board_led_o)
        for (int i = 0; i < 4; i++) begin
            net_i = nv[i];
            repeat (2) @(negedge mclk_i);
            `CHK("diag led", nv[i] != 5'h00, diag_led_o)
        end
        net_i = 5'h03;
        repeat (2) @(negedge mclk_i);
        `CHK("online led", 1'b1, online_led_o)
        `CHK("offline led", 1'b0, offline_led_o)
        `CHK("acyclic led", 1'b1, acyclic_led_o)
        net_i = '0;
        repeat (2) @(negedge mclk_i);
        `CHK("online led idle", 1'b0, online_led_o)
        `CHK("acyclic led idle", 1'b0, acyclic_led_o)
    endtask
    task automatic t_fault;
        for (int i = 1; i < 4; i++) begin
            boot(4'h1, 4'h2);
            selftest_i[i] = 1'b1;
            repeat (2) @(negedge mclk_i);
            `CHK("fault led", 2'b10, board_led_o)
            selftest_i[i] = 1'b0;
            repeat (4) @(negedge mclk_i);
            `CHK("fault led held", 2'b10, board_led_o)
        end
    endtask
    task automatic t_param;
        logic [15:0] nv [4] = '{16'd1, 16'd100, 16'd255, 16'd256};
        logic [15:0] z;
        boot(4'h1, 4'h2);
        for (int i = 0; i < 4; i++) begin
            z = nv[i] - 16'h0001;
            param_num_i = nv[i];
            param_val_i = ~nv[i];
            param_req_i = 1'b1;
            @(negedge mclk_i);
            param_req_i = 1'b0;
            `CHK("param valid", 1'b1, param_valid_o)
            `CHK("param slot", 8'(z / 16'd255), param_loc_o.slot)
            `CHK("param index", 8'(z % 16'd255), param_loc_o.index)
            `CHK("param word", ~nv[i], param_word_o)
            @(negedge mclk_i);
            `CHK("param valid drop", 1'b0, param_valid_o)
        end
    endtask
    initial begin
        t_addr();
        t_rate();
        t_reply();
        t_leds();
        t_fault();
        t_param();
        complete_run();
    end
endmodule
`default_nettype wire
